// ### src/t8cp_core.sv
// 8-bit timer/counter with two compare channels and an Avalon-MM register slave.
// Assumes synchronous inputs on clk_sys and an interrupt controller that pulses
// irq_ack for a serviced request.
//
// Functional notes
// - Counter and compare values are 8 bit
// - One flag register, one mask register
// - Tick from prescaler or external pin, selectable
// - Select zero stops counter, value held
// - Bottom indicated at counter 0x00
// - Maximum indicated at counter 0xFF
// - Top is 0xFF or compare A
// - Each tick clears, increments or decrements
// - Counter readable and writable any time
// - CPU counter write beats counting
// - Three-bit waveform mode split over controls
// - Overflow flag per mode, can interrupt
// - Continuous compare against both values
// - Match flag set on following tick
// - Masked flag interrupts, cleared when serviced
// - Writing one clears a flag
// - Outputs from match, mode, action, extremes
// - Compare double buffered only in PWM
// - Buffer loads at top or bottom only
// - CPU reaches buffer or active value
// - Force strobe updates output in non-PWM modes, no flag
// - Counter write blocks next tick's matches
// - Mode zero wraps, overflow at zero
// - Mode two clears on compare A
// - Modes 3/7 single slope fast PWM
// - Action zero leaves output unchanged
`timescale 1ns/1ps
`include "t8cp_map.svh"

module t8cp_core
  import t8cp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt requests {match_b, match_a, overflow} and service acknowledge
  output logic [2:0]       irq_req,
  input  wire logic [2:0]  irq_ack,
  // Pins
  input  wire logic        external_count_input,
  output logic             compare_a_output,
  output logic             compare_b_output
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  t8cp_state_t s_q;
  t8cp_state_t s_d;

  // ------------------------------------------------------------------
  // Decoded helpers
  // ------------------------------------------------------------------
  logic [2:0]  wgm;
  t8cp_style_t style;
  logic        pwm;
  logic [7:0]  top;
  logic        at_top;
  logic        at_bot;
  logic        at_max;
  logic        hit_a;
  logic        hit_b;
  logic        tick;
  logic        bus_go;
  logic        wr_en;
  logic [2:0]  fl_set;
  logic [2:0]  fl_clr;
  logic [7:0]  wbyte;

  // Waveform mode split over both control registers
  assign wgm = {s_q.wgm_hi, s_q.wgm_lo};
  // PWM modes are the odd codes; reserved codes count as normal
  assign pwm = wgm[0];
  // Top is the fixed maximum or compare A
  assign top = (wgm == `T8CP_WGM_PC_A || wgm == `T8CP_WGM_FP_A) ? s_q.ocra : `T8CP_MAX;
  assign at_top = (s_q.cnt == top);
  assign at_bot = (s_q.cnt == `T8CP_BOTTOM);
  assign at_max = (s_q.cnt == `T8CP_MAX);
  // Comparators run every cycle, ticks only sample them
  assign hit_a = (s_q.cnt == s_q.ocra) && !s_q.block;
  assign hit_b = (s_q.cnt == s_q.ocrb) && !s_q.block;
  // A write is taken on the edge where waitrequest is low
  assign bus_go = !s_q.waitreq;
  assign wr_en = bus_go && avs_write && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Counting style from the waveform mode
  always_comb begin
    case (wgm)
      `T8CP_WGM_CTC:    style = T8CP_CTC;
      `T8CP_WGM_FP_MAX: style = T8CP_FAST;
      `T8CP_WGM_FP_A:   style = T8CP_FAST;
      `T8CP_WGM_PC_MAX: style = T8CP_PHASE;
      `T8CP_WGM_PC_A:   style = T8CP_PHASE;
      default:          style = T8CP_NORMAL;
    endcase
  end

  // Tick source select; an external edge ticks on the first clock that samples it
  always_comb begin
    case (s_q.csel)
      3'h0:    tick = 1'b0;
      3'h1:    tick = 1'b1;
      3'h2:    tick = ((s_q.pre & `T8CP_PRE_8) == `T8CP_PRE_8);
      3'h3:    tick = ((s_q.pre & `T8CP_PRE_64) == `T8CP_PRE_64);
      3'h4:    tick = ((s_q.pre & `T8CP_PRE_256) == `T8CP_PRE_256);
      3'h5:    tick = (s_q.pre == `T8CP_PRE_1024);
      3'h6:    tick = s_q.ext_prev && !external_count_input;
      default: tick = !s_q.ext_prev && external_count_input;
    endcase
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    fl_set = 3'h0;
    fl_clr = 3'h0;
    s_d.pre = s_q.pre + 10'h001;
    s_d.ext_prev = external_count_input;

    // Counter, direction and buffer loads on a tick
    if (tick) begin
      s_d.block = 1'b0;
      case (style)
        T8CP_CTC: begin
          if (s_q.cnt == s_q.ocra) begin
            s_d.cnt = `T8CP_BOTTOM;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
          if (at_max) begin
            fl_set[`T8CP_FL_OVF] = 1'b1;
          end
        end
        T8CP_FAST: begin
          if (at_top) begin
            s_d.cnt = `T8CP_BOTTOM;
            s_d.ocra = s_q.bufa;
            s_d.ocrb = s_q.bufb;
            fl_set[`T8CP_FL_OVF] = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
        T8CP_PHASE: begin
          if (s_q.up && at_top) begin
            s_d.up = 1'b0;
            s_d.cnt = s_q.cnt - 8'h01;
            s_d.ocra = s_q.bufa;
            s_d.ocrb = s_q.bufb;
          end else if (!s_q.up && at_bot) begin
            s_d.up = 1'b1;
            s_d.cnt = s_q.cnt + 8'h01;
            fl_set[`T8CP_FL_OVF] = 1'b1;
          end else if (s_q.up) begin
            s_d.cnt = s_q.cnt + 8'h01;
          end else begin
            s_d.cnt = s_q.cnt - 8'h01;
          end
        end
        default: begin
          s_d.cnt = s_q.cnt + 8'h01;
          if (at_max) begin
            fl_set[`T8CP_FL_OVF] = 1'b1;
          end
        end
      endcase

      // Match flags on the tick after the counter reached the value
      fl_set[`T8CP_FL_MA] = hit_a;
      fl_set[`T8CP_FL_MB] = hit_b;

      // Waveform generation per channel
      case (style)
        T8CP_FAST: begin
          if (s_q.coma == 2'h1 && wgm == `T8CP_WGM_FP_A && hit_a) begin
            s_d.oca = !s_q.oca;
          end else if (s_q.coma[1] && hit_a) begin
            s_d.oca = s_q.coma[0];
          end else if (s_q.coma[1] && at_top) begin
            s_d.oca = !s_q.coma[0];
          end
          if (s_q.comb[1] && hit_b) begin
            s_d.ocb = s_q.comb[0];
          end else if (s_q.comb[1] && at_top) begin
            s_d.ocb = !s_q.comb[0];
          end
        end
        T8CP_PHASE: begin
          // Up-count match drives the action level, down-count its inverse
          if (s_q.coma[1] && hit_a) begin
            s_d.oca = s_q.up ? s_q.coma[0] : !s_q.coma[0];
          end
          if (s_q.comb[1] && hit_b) begin
            s_d.ocb = s_q.up ? s_q.comb[0] : !s_q.comb[0];
          end
        end
        default: begin
          if (hit_a) begin
            case (s_q.coma)
              2'h1:    s_d.oca = !s_q.oca;
              2'h2:    s_d.oca = 1'b0;
              2'h3:    s_d.oca = 1'b1;
              default: s_d.oca = s_q.oca;
            endcase
          end
          if (hit_b) begin
            case (s_q.comb)
              2'h1:    s_d.ocb = !s_q.ocb;
              2'h2:    s_d.ocb = 1'b0;
              2'h3:    s_d.ocb = 1'b1;
              default: s_d.ocb = s_q.ocb;
            endcase
          end
        end
      endcase
    end

    // Bus handshake: one wait cycle, then the answer edge
    s_d.waitreq = 1'b1;
    if (s_q.waitreq && (avs_read || avs_write)) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = 32'h0000_0000;
      case (avs_address)
        `T8CP_OFS_CTRL_A: s_d.rdata[7:0] = {s_q.coma, s_q.comb, 2'h0, s_q.wgm_lo};
        `T8CP_OFS_CTRL_B: s_d.rdata[7:0] = {4'h0, s_q.wgm_hi, s_q.csel};
        `T8CP_OFS_COUNT:  s_d.rdata[7:0] = s_q.cnt;
        `T8CP_OFS_CMP_A:  s_d.rdata[7:0] = pwm ? s_q.bufa : s_q.ocra;
        `T8CP_OFS_CMP_B:  s_d.rdata[7:0] = pwm ? s_q.bufb : s_q.ocrb;
        `T8CP_OFS_MASK:   s_d.rdata[7:0] = {5'h00, s_q.mask};
        `T8CP_OFS_FLAG:   s_d.rdata[7:0] = {5'h00, s_q.flag};
        default:          s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes, applied after the tick so the CPU wins except against a flag set
    if (wr_en) begin
      case (avs_address)
        `T8CP_OFS_CTRL_A: begin
          s_d.coma = wbyte[`T8CP_CA_COMA_HI:`T8CP_CA_COMA_LO];
          s_d.comb = wbyte[`T8CP_CA_COMB_HI:`T8CP_CA_COMB_LO];
          s_d.wgm_lo = wbyte[1:0];
        end
        `T8CP_OFS_CTRL_B: begin
          s_d.csel = wbyte[2:0];
          s_d.wgm_hi = wbyte[`T8CP_CB_WGM2];
          // Force strobes act only in non-PWM modes and never set a flag
          if (!pwm && wbyte[`T8CP_CB_FORCE_A]) begin
            case (s_q.coma)
              2'h1:    s_d.oca = !s_q.oca;
              2'h2:    s_d.oca = 1'b0;
              2'h3:    s_d.oca = 1'b1;
              default: s_d.oca = s_q.oca;
            endcase
          end
          if (!pwm && wbyte[`T8CP_CB_FORCE_B]) begin
            case (s_q.comb)
              2'h1:    s_d.ocb = !s_q.ocb;
              2'h2:    s_d.ocb = 1'b0;
              2'h3:    s_d.ocb = 1'b1;
              default: s_d.ocb = s_q.ocb;
            endcase
          end
        end
        `T8CP_OFS_COUNT: begin
          s_d.cnt = wbyte;
          s_d.block = 1'b1;
        end
        `T8CP_OFS_CMP_A: begin
          s_d.bufa = wbyte;
          if (!pwm) begin
            s_d.ocra = wbyte;
          end
        end
        `T8CP_OFS_CMP_B: begin
          s_d.bufb = wbyte;
          if (!pwm) begin
            s_d.ocrb = wbyte;
          end
        end
        `T8CP_OFS_MASK: s_d.mask = wbyte[2:0];
        `T8CP_OFS_FLAG: fl_clr = wbyte[2:0];
        default: ;
      endcase
    end

    // Flags: a set in the same cycle beats any clear
    s_d.flag = (s_q.flag & ~(fl_clr | irq_ack)) | fl_set;
    // Requests follow the new flags, gated by the mask as it stood
    s_d.irq = s_d.flag & s_q.mask;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.up <= 1'b1;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs straight from the state register
  // ------------------------------------------------------------------
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign irq_req = s_q.irq;
  assign compare_a_output = s_q.oca;
  assign compare_b_output = s_q.ocb;

endmodule : t8cp_core

// ### include/t8cp_map.svh
// Register map, field positions, reset values and mode codes of the timer core.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
`ifndef T8CP_MAP_SVH
`define T8CP_MAP_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define T8CP_OFS_CTRL_A 5'h00
`define T8CP_OFS_CTRL_B 5'h04
`define T8CP_OFS_COUNT  5'h08
`define T8CP_OFS_CMP_A  5'h0C
`define T8CP_OFS_CMP_B  5'h10
`define T8CP_OFS_MASK   5'h14
`define T8CP_OFS_FLAG   5'h18

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define T8CP_CA_COMA_HI 7
`define T8CP_CA_COMA_LO 6
`define T8CP_CA_COMB_HI 5
`define T8CP_CA_COMB_LO 4
`define T8CP_CB_FORCE_A 7
`define T8CP_CB_FORCE_B 6
`define T8CP_CB_WGM2    3
`define T8CP_FL_OVF     0
`define T8CP_FL_MA      1
`define T8CP_FL_MB      2

// ------------------------------------------------------------------
// Values
// ------------------------------------------------------------------
`define T8CP_BOTTOM     8'h00
`define T8CP_MAX        8'hFF
`define T8CP_RST_BYTE   8'h00
`define T8CP_WGM_NORMAL 3'h0
`define T8CP_WGM_PC_MAX 3'h1
`define T8CP_WGM_CTC    3'h2
`define T8CP_WGM_FP_MAX 3'h3
`define T8CP_WGM_PC_A   3'h5
`define T8CP_WGM_FP_A   3'h7
`define T8CP_PRE_8      10'h007
`define T8CP_PRE_64     10'h03F
`define T8CP_PRE_256    10'h0FF
`define T8CP_PRE_1024   10'h3FF

`endif

// ### include/t8cp_pkg.sv
// Types shared by the timer core: mode enumeration and state record.
// Assumes t8cp_map.svh supplies the numeric constants.
package t8cp_pkg;

  // ------------------------------------------------------------------
  // Counting style derived from the waveform mode
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {T8CP_NORMAL, T8CP_CTC, T8CP_FAST, T8CP_PHASE} t8cp_style_t;

  // ------------------------------------------------------------------
  // Whole state of the core
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cnt;
    logic        up;
    logic [7:0]  ocra;
    logic [7:0]  ocrb;
    logic [7:0]  bufa;
    logic [7:0]  bufb;
    logic [1:0]  coma;
    logic [1:0]  comb;
    logic [1:0]  wgm_lo;
    logic        wgm_hi;
    logic [2:0]  csel;
    logic [2:0]  mask;
    logic [2:0]  flag;
    logic        block;
    logic        oca;
    logic        ocb;
    logic [9:0]  pre;
    logic        ext_prev;
    logic        waitreq;
    logic [31:0] rdata;
    logic [2:0]  irq;
  } t8cp_state_t;

endpackage : t8cp_pkg

// ### test/t8cp_core_sva.sv
// Port checker for the timer core: bus handshake, read values, flags, outputs.
// Assumes a bind to t8cp_core; clock select and mask are shadowed from bus writes.
`timescale 1ns/1ps
`include "t8cp_map.svh"

module t8cp_core_sva
  import t8cp_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Interrupts and pins
  input wire logic [2:0]  irq_req,
  input wire logic [2:0]  irq_ack,
  input wire logic        external_count_input,
  input wire logic        compare_a_output,
  input wire logic        compare_b_output
);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [2:0] csel_q;
  logic [2:0] mask_q;
  logic       idle_q;
  logic       ans_wr;
  logic       stop;
  logic       unmapped;
  logic [1:0] outs;
  assign ans_wr   = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign stop     = idle_q && (csel_q == 3'h0);  // Two idle cycles: no tick in flight
  assign outs     = {compare_a_output, compare_b_output};
  assign unmapped = !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18});
  // Taken at the answer edge, like the core itself
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      csel_q <= 3'h0;
      mask_q <= 3'h0;
      idle_q <= 1'h1;
    end else begin
      if (ans_wr && avs_address == `T8CP_OFS_CTRL_B) begin
        csel_q <= avs_writedata[2:0];
      end
      if (ans_wr && avs_address == `T8CP_OFS_MASK) begin
        mask_q <= avs_writedata[2:0];
      end
      idle_q <= (csel_q == 3'h0);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_s;
    avs_read && avs_waitrequest;
  endsequence
  sequence ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("bus request not answered in one cycle");
  read_upper_a: assert property (rd_s |=> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  read_unmap_a: assert property (rd_s ##0 unmapped |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  force_read_a: assert property (rd_s ##0 (avs_address == 5'h04) |=> avs_readdata[7:6] == 2'h0)
    else $error("force strobes read back nonzero");
  stop_hold_a: assert property (stop && !avs_write |=> $stable(outs))
    else $error("compare outputs moved while stopped");
  ack_clear_a: assert property (stop && |irq_ack |-> ##2 (irq_req & $past(irq_ack, 2)) == 3'h0)
    else $error("serviced request still raised");
  w1c_clear_a: assert property (stop && ans_wr && avs_address == 5'h18 |-> ##2
    (irq_req & $past(avs_writedata[2:0], 2)) == 3'h0)
    else $error("flag not cleared by write of one");
  mask_gate_a: assert property ((irq_req & ~mask_q & ~$past(mask_q)) == 3'h0)
    else $error("request raised with mask bit off");
endmodule : t8cp_core_sva

bind t8cp_core t8cp_core_sva u_sva (
  .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .irq_req, .irq_ack, .external_count_input,
  .compare_a_output, .compare_b_output
);

// ### test/tb.sv
// Self-checking bench for the timer core: registers, ticks, flags and outputs.
// Assumes a 25 MHz clock; timer ticks come from the external count pin except in the tick source test.
`timescale 1ns/1ps
`include "t8cp_map.svh"

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [4:0] RA = `T8CP_OFS_CTRL_A;
  localparam logic [4:0] RB = `T8CP_OFS_CTRL_B;
  localparam logic [4:0] RC = `T8CP_OFS_COUNT;
  localparam logic [4:0] RF = `T8CP_OFS_FLAG;
  logic        clk_sys = 1'h0;
  logic        rstn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  irq_req;
  logic [2:0]  irq_ack;
  logic        ext_in;
  logic        out_a;
  logic        out_b;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;

  t8cp_core DUT (
    .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .irq_req, .irq_ack, .external_count_input(ext_in),
    .compare_a_output(out_a), .compare_b_output(out_b)
  );

  // Clock, and a ceiling well above the few hundred cycles the tests need
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= ~w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0) begin
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask : rc
  // One rising edge on the count pin per tick, slow enough to be seen
  task automatic tk(input int n);
    repeat (n) begin
      ext_in <= 1'h1;
      repeat (3) @(posedge clk_sys);
      ext_in <= 1'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask : tk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rst();
    for (int i = 0; i < 8; i++) begin
      rc(5'(i * 4), 8'h00);
    end
    $display("reset values done");
  endtask : t_rst
  task automatic t_hold();
    wr(RC, 8'h5A);
    tk(2);
    rc(RC, 8'h5A);
    avs_byteenable <= 4'hE;
    wr(RC, 8'h11);
    avs_byteenable <= 4'hF;
    rc(RC, 8'h5A);
    $display("stopped counter done");
  endtask : t_hold
  task automatic t_modes();
    logic [2:0] md [3] = '{3'h0, 3'h3, 3'h1};
    logic [7:0] nx [3] = '{8'h00, 8'h00, 8'hFE};
    logic [7:0] fl [3] = '{8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 3; i++) begin
      wr(RA, {6'h00, md[i][1:0]});
      wr(RB, {4'h0, md[i][2], 3'h7});
      wr(RF, 8'h07);
      wr(RC, 8'hFE);
      tk(1);
      rc(RC, 8'hFF);
      tk(1);
      rc(RC, nx[i]);
      rc(RF, fl[i]);
    end
    wr(RB, 8'h00);
    $display("count modes done");
  endtask : t_modes
  task automatic t_match();
    wr(RA, 8'h00);
    wr(`T8CP_OFS_MASK, 8'h07);
    wr(RF, 8'h07);
    wr(`T8CP_OFS_CMP_A, 8'h10);
    wr(RC, 8'h10);
    wr(RB, 8'h07);
    tk(1);
    rc(RF, 8'h00);
    wr(`T8CP_OFS_CMP_A, 8'h11);
    tk(1);
    rc(RF, 8'h02);
    chk({29'h0, irq_req}, 32'h2);
    wr(RB, 8'h00);
    irq_ack <= 3'h2;
    @(posedge clk_sys);
    irq_ack <= 3'h0;
    repeat (2) @(posedge clk_sys);
    chk({29'h0, irq_req}, 32'h0);
    rc(RF, 8'h00);
    $display("match flags done");
  endtask : t_match
  task automatic t_ctc();
    wr(`T8CP_OFS_CMP_A, 8'h03);
    wr(RA, 8'h02);
    wr(RC, 8'h00);
    wr(RB, 8'h07);
    tk(4);
    rc(RC, 8'h00);
    chk({31'h0, out_a}, 32'h0);
    wr(RA, 8'h42);
    tk(4);
    chk({31'h0, out_a}, 32'h1);
    rc(RC, 8'h00);
    $display("clear on match done");
  endtask : t_ctc
  task automatic t_force();
    wr(RB, 8'h00);
    wr(RA, 8'h70);
    wr(RF, 8'h07);
    wr(RC, 8'h20);
    wr(RB, 8'hC0);
    chk({31'h0, out_a}, 32'h0);
    chk({31'h0, out_b}, 32'h1);
    rc(RF, 8'h00);
    rc(RC, 8'h20);
    rc(RB, 8'h00);
    $display("forced compare done");
  endtask : t_force
  // Fast PWM on channel B: old active value matches until the top loads the buffer
  task automatic t_buf();
    wr(`T8CP_OFS_CMP_B, 8'h02);
    wr(RA, 8'h23);
    wr(`T8CP_OFS_CMP_B, 8'h05);
    rc(`T8CP_OFS_CMP_B, 8'h05);
    wr(RF, 8'h07);
    wr(RC, 8'h01);
    wr(RB, 8'h07);
    tk(2);
    chk({31'h0, out_b}, 32'h0);
    rc(RF, 8'h04);
    wr(RC, 8'hFE);
    tk(2);
    chk({31'h0, out_b}, 32'h1);
    tk(3);
    chk({31'h0, out_b}, 32'h1);
    tk(3);
    chk({31'h0, out_b}, 32'h0);
    wr(RB, 8'h00);
    $display("double buffering done");
  endtask : t_buf
  // Tick sources: every clock, divide by 8 over 64 clocks, falling pin edge
  task automatic t_clk();
    wr(RC, 8'h00);
    wr(RB, 8'h01);
    wr(RB, 8'h00);
    rc(RC, 8'h03);
    wr(RC, 8'h00);
    wr(RB, 8'h02);
    repeat (61) @(posedge clk_sys);
    wr(RB, 8'h00);
    rc(RC, 8'h08);
    wr(RB, 8'h06);
    wr(RC, 8'h10);
    tk(1);
    rc(RC, 8'h11);
    wr(RB, 8'h00);
    $display("tick sources done");
  endtask : t_clk

  initial begin
    rstn           = 1'h0;
    avs_address    = 5'h00;
    avs_read       = 1'h0;
    avs_write      = 1'h0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hF;
    irq_ack        = 3'h0;
    ext_in         = 1'h0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    t_rst();
    t_hold();
    t_modes();
    t_match();
    t_ctc();
    t_force();
    t_buf();
    t_clk();
    end_sim();
  end
endmodule : tb
